// File: src/ddrbs_pkg.sv
// Constants, reset values and state type of the burst SRAM port control.
// Assumes a single core clock that oversamples the link clock pins.
//==========================================================================
package ddrbs_pkg;

    // Core clock and pin sampling
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_STAGES   = 3;

    // Documented widths of the widest variant
    localparam int DATA_W_DEF    = 36;
    localparam int LANE_W_DEF    = 9;
    localparam int ADDR_W_DEF    = 19;   // 512K locations per array
    localparam int BURST_WORDS   = 2;

    // Reset values of pin-facing registers
    localparam logic RST_VALID   = 1'b0;
    localparam logic RST_OE      = 1'b0;
    localparam logic RST_ECHO    = 1'b0;
    localparam logic RST_K_LVL   = 1'b0;   // Positive link clock idles low
    localparam logic RST_KN_LVL  = 1'b1;   // Negative link clock idles high

    // Burst sequencer
    typedef enum logic [1:0] {
        DDRBS_IDLE,
        DDRBS_WR_BEAT1,
        DDRBS_RD_BEAT0,
        DDRBS_RD_BEAT1
    } ddrbs_state_e;

endpackage

// File: src/ddrbs_array_if.sv
// Port bundle between the burst sequencer and one word array.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps

interface ddrbs_array_if #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 36,
    parameter int LANES  = 4
);
    logic              wrEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic [LANES-1:0]  laneEn;
    logic [DATA_W-1:0] rdData;

    modport ctrl (output wrEn, output addr, output wrData, output laneEn, input rdData);
    modport mem  (input wrEn, input addr, input wrData, input laneEn, output rdData);
endinterface

// File: src/ddrbs_word_array.sv
// One word array of the burst pair, with per-lane write gating.
// Assumes write strobe, lane enables and data are valid for one core clock.
`timescale 1ns/10ps

module ddrbs_word_array
    import ddrbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter int LANE_W = LANE_W_DEF
)(
    input  wire logic clock,
    ddrbs_array_if.mem port
);
    localparam int LANES = DATA_W / LANE_W;
    localparam int DEPTH = 2 ** ADDR_W;

    //======================================================================
    // Storage, one slice per lane
    //======================================================================
    // No reset: contents are undefined at power up, as in the real part
    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++)
        begin : g_lane
            logic [LANE_W-1:0] mem [DEPTH];
            // Lane written only when its select is active
            always_ff @(posedge clock)
            begin
                if (port.wrEn && port.laneEn[gl])
                begin
                    mem[port.addr] <= port.wrData[gl*LANE_W +: LANE_W];
                end
            end
            assign port.rdData[gl*LANE_W +: LANE_W] = mem[port.addr];
        end
    endgenerate

endmodule // ddrbs_word_array

// File: src/ddrbs_port_ctrl.sv
// Top of the burst SRAM port: pin sampling, burst sequencing, echo clocks.
// Assumes link clocks far slower than the core clock, and a controller
// that holds pins steady around each link clock rise.
`timescale 1ns/10ps

module ddrbs_port_ctrl
    import ddrbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter int LANE_W = LANE_W_DEF   // 4 gives the nibble-select variant
)(
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       k_clk,
    input  wire logic                       k_clk_n,
    input  wire logic                       cycle_load_n,
    input  wire logic                       read_write,
    input  wire logic [ADDR_W-1:0]          addr,
    input  wire logic [DATA_W-1:0]          dq_in,
    input  wire logic [DATA_W/LANE_W-1:0]   lane_write_sel_n,
    output logic      [DATA_W-1:0]          dq_out,
    output logic                            dq_oe,
    output logic                            output_valid,
    output logic                            echo_clk,
    output logic                            echo_clk_n
);
    localparam int LANES = DATA_W / LANE_W;
    localparam int SW    = 4 + ADDR_W + DATA_W + LANES;
    // Link clock bits start at their idle levels, so no false edge after reset
    localparam logic [SW-1:0] SYNC_RST = {RST_K_LVL, RST_KN_LVL, {(SW-2){1'b0}}};

    //======================================================================
    // Parameter checks
    //======================================================================
    if (DATA_W % LANE_W != 0 || LANES < 1 || ADDR_W < 1)
    begin : g_bad_width
        $error("ddrbs_port_ctrl: unsupported width parameters");
    end

    //======================================================================
    // Pin synchronisers
    //======================================================================
    // All pins share one three-stage chain so data, selects and clocks
    // keep their relative timing through the crossing.
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic [SW-1:0] sync3_ff;
    logic [SW-1:0] nxt_sync1;

    always_comb
    begin
        nxt_sync1 = {k_clk, k_clk_n, cycle_load_n, read_write, addr, dq_in, lane_write_sel_n};
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
            sync3_ff <= SYNC_RST;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    logic              sK;
    logic              sKn;
    logic              sLoadN;
    logic              sRead;
    logic [ADDR_W-1:0] sAddr;
    logic [DATA_W-1:0] sData;
    logic [LANES-1:0]  sSelN;

    assign {sK, sKn, sLoadN, sRead, sAddr, sData, sSelN} = sync3_ff;

    //======================================================================
    // Link clock edge finders
    //======================================================================
    // A level counts only once stages two and three agree
    logic kLvl_ff;
    logic knLvl_ff;
    logic nxt_kLvl;
    logic nxt_knLvl;
    logic kRise;
    logic knRise;

    always_comb
    begin
        nxt_kLvl  = kLvl_ff;
        nxt_knLvl = knLvl_ff;
        if (sync2_ff[SW-1] == sK)
        begin
            nxt_kLvl = sK;
        end
        if (sync2_ff[SW-2] == sKn)
        begin
            nxt_knLvl = sKn;
        end
        kRise  = nxt_kLvl & ~kLvl_ff;
        knRise = nxt_knLvl & ~knLvl_ff;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kLvl_ff  <= RST_K_LVL;
            knLvl_ff <= RST_KN_LVL;
        end
        else
        begin
            kLvl_ff  <= nxt_kLvl;
            knLvl_ff <= nxt_knLvl;
        end
    end

    //======================================================================
    // Word arrays
    //======================================================================
    ddrbs_array_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) arr0 ();
    ddrbs_array_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) arr1 ();

    // One array per burst word
    ddrbs_word_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANE_W(LANE_W)) u_word0 (
        .clock (clock),
        .port  (arr0.mem)
    );
    ddrbs_word_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANE_W(LANE_W)) u_word1 (
        .clock (clock),
        .port  (arr1.mem)
    );

    //======================================================================
    // Burst sequencer and output drivers
    //======================================================================
    ddrbs_state_e      state_ff;
    ddrbs_state_e      nxt_state;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic [DATA_W-1:0] dout_ff;
    logic [DATA_W-1:0] nxt_dout;
    logic              oe_ff;
    logic              nxt_oe;
    logic              valid_ff;
    logic              nxt_valid;
    logic              echo_ff;
    logic              echoN_ff;

    // Write strobes and lane enables from the beat sampled at this edge
    always_comb
    begin
        arr0.wrEn   = kRise && !sLoadN && !sRead;
        arr1.wrEn   = knRise && state_ff == DDRBS_WR_BEAT1;
        arr0.addr   = kRise ? sAddr : addr_ff;
        arr1.addr   = addr_ff;
        arr0.wrData = sData;
        arr1.wrData = sData;
        arr0.laneEn = ~sSelN;
        arr1.laneEn = ~sSelN;
    end

    // Next state on each link clock rise; holds between rises
    always_comb
    begin
        nxt_state = state_ff;
        nxt_addr  = addr_ff;
        nxt_dout  = dout_ff;
        nxt_oe    = oe_ff;
        nxt_valid = valid_ff;
        if (kRise)
        begin
            // Second read word leaves on the positive clock
            if (state_ff == DDRBS_RD_BEAT1)
            begin
                nxt_dout  = arr1.rdData;
                nxt_oe    = 1'b1;
                nxt_valid = 1'b1;
            end
            if (!sLoadN)
            begin
                nxt_addr  = sAddr;
                nxt_state = sRead ? DDRBS_RD_BEAT0 : DDRBS_WR_BEAT1;
            end
            else
            begin
                nxt_state = DDRBS_IDLE;
            end
        end
        else if (knRise)
        begin
            case (state_ff)
                DDRBS_RD_BEAT0:
                begin
                    nxt_dout  = arr0.rdData;
                    nxt_oe    = 1'b1;
                    nxt_valid = 1'b1;
                    nxt_state = DDRBS_RD_BEAT1;
                end
                default:
                begin
                    // Burst over: float the pins, drop valid
                    nxt_oe    = 1'b0;
                    nxt_valid = 1'b0;
                    nxt_state = DDRBS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= DDRBS_IDLE;
            addr_ff  <= '0;
            dout_ff  <= '0;
            oe_ff    <= RST_OE;
            valid_ff <= RST_VALID;
            echo_ff  <= RST_ECHO;
            echoN_ff <= ~RST_ECHO;
        end
        else
        begin
            state_ff <= nxt_state;
            addr_ff  <= nxt_addr;
            dout_ff  <= nxt_dout;
            oe_ff    <= nxt_oe;
            valid_ff <= nxt_valid;
            echo_ff  <= nxt_kLvl;
            echoN_ff <= ~nxt_kLvl;
        end
    end

    // Valid, data and echo all switch on the same core edge
    assign dq_out       = dout_ff;
    assign dq_oe        = oe_ff;
    assign output_valid = valid_ff;
    assign echo_clk     = echo_ff;
    assign echo_clk_n   = echoN_ff;

endmodule // ddrbs_port_ctrl

// File: tb/ddrbs_port_props.sv
// Checker of the burst SRAM port pins, bound to the port top.
// Assumes complementary link clocks held steady for 8 core clocks.
`timescale 1ns/10ps

module ddrbs_port_props
    import ddrbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter int LANE_W = LANE_W_DEF
)(
    input wire logic                     clock,
    input wire logic                     rst_n,
    input wire logic                     k_clk,
    input wire logic                     k_clk_n,
    input wire logic                     cycle_load_n,
    input wire logic                     read_write,
    input wire logic [ADDR_W-1:0]        addr,
    input wire logic [DATA_W-1:0]        dq_in,
    input wire logic [DATA_W/LANE_W-1:0] lane_write_sel_n,
    input wire logic [DATA_W-1:0]        dq_out,
    input wire logic                     dq_oe,
    input wire logic                     output_valid,
    input wire logic                     echo_clk,
    input wire logic                     echo_clk_n
);
    //======================================================================
    // Clocking and load sequences
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence readLoadS;
        $rose(k_clk) && !cycle_load_n && read_write;
    endsequence
    sequence writeLoadS;
        $rose(k_clk) && !cycle_load_n && !read_write;
    endsequence

    //======================================================================
    // Echo clocks and output timing
    echo_pair_a: assert property (echo_clk_n != echo_clk)
        else $error("echo clocks not complementary");
    echo_rise_a: assert property ($rose(k_clk) |-> ##[2:6] echo_clk)
        else $error("echo clock missed a rise");
    echo_fall_a: assert property ($fell(k_clk) |-> ##[2:6] !echo_clk)
        else $error("echo clock missed a fall");
    valid_oe_a: assert property (output_valid == dq_oe)
        else $error("valid and drive disagree");
    valid_align_a: assert property ($changed(output_valid) |-> $fell(echo_clk))
        else $error("valid moved off an echo edge");
    data_align_a: assert property (dq_oe && $changed(dq_out) |-> $changed(echo_clk))
        else $error("read data moved off an echo edge");
    read_drive_a: assert property (readLoadS |-> ##[9:14] dq_oe)
        else $error("read load gave no data");
    write_quiet_a: assert property (writeLoadS |-> ##[9:14] !dq_oe)
        else $error("write load left data driven");
endmodule // ddrbs_port_props

bind ddrbs_port_ctrl ddrbs_port_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANE_W(LANE_W))
    props_u (.clock(clock), .rst_n(rst_n), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .cycle_load_n(cycle_load_n), .read_write(read_write), .addr(addr), .dq_in(dq_in),
    .lane_write_sel_n(lane_write_sel_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .output_valid(output_valid), .echo_clk(echo_clk), .echo_clk_n(echo_clk_n));

// File: tb/ddrbs_ctrl_model.sv
// Memory controller model driving link clocks, load, address and data.
// Assumes calls start at a falling core clock edge.
`timescale 1ns/10ps

module ddrbs_ctrl_model #(
    parameter int ADDR_W = 4
)(
    input  wire logic              clock,
    output logic                   k_clk,
    output logic                   k_clk_n,
    output logic                   cycle_load_n,
    output logic                   read_write,
    output logic [ADDR_W-1:0]      addr,
    output logic [35:0]            dq_in,
    output logic [3:0]             lane_write_sel_n
);
    //======================================================================
    // Link idles with clocks still and nothing loaded
    initial
    begin
        {k_clk, k_clk_n, cycle_load_n, read_write} = 4'h6;
        addr = '0;
        dq_in = '0;
        lane_write_sel_n = 4'hf;
    end

    // One half link period; pins set 3 core clocks before the edge
    task automatic step(input logic kLvl, input logic ld, input logic rw,
                        input logic [ADDR_W-1:0] a, input logic [35:0] d, input logic [3:0] s);
        cycle_load_n = ld;
        read_write = rw;
        addr = a;
        dq_in = d;
        lane_write_sel_n = s;
        repeat (3) @(negedge clock);
        k_clk = kLvl;
        k_clk_n = !kLvl;
        repeat (5) @(negedge clock);
    endtask
endmodule // ddrbs_ctrl_model

// File: tb/ddr_burst_sram_port_control_tb.sv
// Self-checking bench of the burst SRAM port control.
// Assumes the controller model owns every link pin.
`timescale 1ns/10ps

module ddr_burst_sram_port_control_tb;
    import ddrbs_pkg::*;
    logic              clock, rst_n, kClk, kClkN, loadN, readWrite, prevRd;
    logic [3:0]        addr, sel, prevA;
    logic [35:0]       dqIn, dqOut, lfsrSt, mem0 [16], mem1 [16];
    logic              dqOe, outputValid, echoClk, echoClkN;
    int                nMismatch, checksDone, cycles;

    //======================================================================
    // Clock, design and partner
    always #5 clock = !clock;
    ddrbs_port_ctrl #(.ADDR_W(4)) dut_u (.clock(clock), .rst_n(rst_n), .k_clk(kClk),
        .k_clk_n(kClkN), .cycle_load_n(loadN), .read_write(readWrite), .addr(addr),
        .dq_in(dqIn), .lane_write_sel_n(sel), .dq_out(dqOut), .dq_oe(dqOe),
        .output_valid(outputValid), .echo_clk(echoClk), .echo_clk_n(echoClkN));
    ddrbs_ctrl_model #(.ADDR_W(4)) model_u (.clock(clock), .k_clk(kClk), .k_clk_n(kClkN),
        .cycle_load_n(loadN), .read_write(readWrite), .addr(addr), .dq_in(dqIn),
        .lane_write_sel_n(sel));

    //======================================================================
    // Helpers: random source, lane merge, compare, verdict
    function automatic logic [35:0] rnd();
        lfsrSt = {lfsrSt[34:0], lfsrSt[35] ^ lfsrSt[24]};
        return lfsrSt;
    endfunction
    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] s);
        for (int i = 0; i < 4; i++)
            if (!s[i]) o[i*9 +: 9] = n[i*9 +: 9];
        return o;
    endfunction
    task automatic check(input string nm, input logic [35:0] seen, exp);
        checksDone++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One link period: load edge then second-beat edge, checked against the reference arrays mem0 and mem1
    task automatic xfer(input logic ld, rw, input logic [3:0] a, input logic full);
        logic [35:0] d0, d1, r0, r1;
        d0 = rnd();
        d1 = rnd();
        r0 = rnd();
        r1 = rnd();
        if (full) {r0[3:0], r1[3:0]} = 8'h00;
        model_u.step(1'b1, !ld, rw, a, d0, r0[3:0]);
        if (prevRd) check("beat1", dqOut, mem1[prevA]);
        if (ld && !rw) mem0[a] = merge(mem0[a], d0, r0[3:0]);
        model_u.step(1'b0, 1'b1, rw, a, d1, r1[3:0]);
        if (ld && !rw) mem1[a] = merge(mem1[a], d1, r1[3:0]);
        prevRd = ld && rw;
        prevA = a;
        check("oe_valid", {34'h0, dqOe, outputValid}, {34'h0, {2{prevRd}}});
        if (prevRd) check("beat0", dqOut, mem0[a]);
    endtask

    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            nMismatch++;
            giveVerdict();
        end
    end

    //======================================================================
    // Main sequence
    initial
    begin
        {clock, rst_n, prevRd, prevA} = 7'h00;
        lfsrSt = 36'h000010416;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        check("reset", {dqOut[31:0], dqOe, outputValid, echoClk, echoClkN}, 36'h1);
        $display("test reset done");
        for (int a = 0; a < 16; a++) xfer(1'b1, 1'b0, 4'(a), 1'b1);
        $display("test fill done");
        for (int i = 0; i < 40; i++)
        begin
            lfsrSt = rnd();
            xfer(lfsrSt[0] | lfsrSt[1], lfsrSt[2], lfsrSt[7:4], 1'b0);
        end
        $display("test random done");
        xfer(1'b1, 1'b1, 4'h3, 1'b0);
        xfer(1'b1, 1'b1, 4'h3, 1'b0);
        xfer(1'b1, 1'b0, 4'h3, 1'b0);
        xfer(1'b1, 1'b1, 4'h3, 1'b0);
        xfer(1'b0, 1'b1, 4'h3, 1'b0);
        $display("test corners done");
        giveVerdict();
    end
endmodule // ddr_burst_sram_port_control_tb
